// ==== inc/ctd_ovr_if.sv ====
`default_nettype none
interface ctd_ovr_if;
   logic [31:0] override_reg;
   logic [31:0] trace_reg;
   modport regs (output override_reg, output trace_reg);
   modport ctrl (input override_reg, input trace_reg);
endinterface
`default_nettype wire

// ==== inc/ctd_pkg.sv ====
`default_nettype none
package ctd_pkg;
   // Transfer selector fields
   localparam logic [3:0] CTD_PRIMARY_REG    = 4'hF;
   localparam logic [3:0] CTD_SEC_REG_ADDR   = 4'h1;
   localparam logic [2:0] CTD_OP1_ADDR       = 3'h0;
   localparam logic [2:0] CTD_OP1_TRACE      = 3'h1;
   localparam logic [2:0] CTD_OP2_ADDR       = 3'h0;
   localparam logic [2:0] CTD_OP1_OVERRIDE   = 3'h0;
   localparam logic [3:0] CTD_SEC_REG_OVR    = 4'h0;
   localparam logic [2:0] CTD_OP2_OVERRIDE   = 3'h0;
   // Override field positions
   localparam int         CTD_OVR_CLEAN_ALL  = 19;
   localparam int         CTD_OVR_ABORT_D    = 18;
   localparam int         CTD_OVR_ABORT_I    = 17;
   localparam int         CTD_OVR_NO_PREF    = 16;
   localparam int         CTD_OVR_NO_CGATE   = 15;
   localparam int         CTD_OVR_FORCE_UNBUF = 14;
   localparam int         CTD_OVR_MMUOFF_WRTHRU = 13;
   localparam logic [31:0] CTD_OVR_MASK      = 32'h000F_E000;
   localparam logic [31:0] CTD_OVR_RESET     = 32'h0000_0000;
   // Trace control field positions
   localparam int         CTD_TRC_FIQ        = 2;
   localparam int         CTD_TRC_IRQ        = 1;
   localparam logic [31:0] CTD_TRC_MASK      = 32'h0000_0006;
   localparam logic [31:0] CTD_TRC_RESET     = 32'h0000_0000;
   localparam logic [31:0] CTD_ADDR_RESET    = 32'h0000_0000;
   // Fault status written on an aborted translation miss
   localparam logic [3:0] CTD_FAULT_XLATE    = 4'h0;
   // Data access policy encodings
   typedef enum logic [1:0] {
      CTD_POL_UNCACHED,
      CTD_POL_BUFFERED,
      CTD_POL_WRTHRU,
      CTD_POL_WRBACK
   } ctd_policy_e;
endpackage
`default_nettype wire

// ==== sim/ctd_core_model.sv ====
`default_nettype none
// ==========
// Core side issuing transfers
module ctd_core_model
   import ctd_pkg::*;
(
   // Clock
   input  wire logic   clk_in,
   // Transfer
   output logic        vld_out = 1'b0,
   output logic        dir_out = 1'b0,
   output logic [13:0] sel_out = 14'h0000,
   output logic [31:0] wd_out = 32'h0000_0000
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [13:0] S_ADR = {CTD_PRIMARY_REG, CTD_OP1_ADDR, CTD_SEC_REG_ADDR, CTD_OP2_ADDR};
   localparam logic [13:0] S_TRC = {CTD_PRIMARY_REG, CTD_OP1_TRACE, CTD_SEC_REG_ADDR, CTD_OP2_ADDR};
   localparam logic [13:0] S_OVR = {CTD_PRIMARY_REG, CTD_OP1_OVERRIDE, CTD_SEC_REG_OVR, CTD_OP2_OVERRIDE};
   // one transfer; entered just after an edge, held over the next
   task automatic xfer(input logic d, input logic [13:0] s, input logic [31:0] w);
      vld_out = 1'b1;
      dir_out = d;
      sel_out = s;
      w = s == S_OVR ? w & CTD_OVR_MASK : (s == S_TRC ? w & CTD_TRC_MASK : w);
      // Unused data lines toggle so a stale word can never pass for a good one
      wd_out = d ? w : ~wd_out;
      @(posedge clk_in);
      #1;
   endtask
   task automatic idle();
      vld_out = 1'b0;
      wd_out = ~wd_out;
      @(posedge clk_in);
      #1;
   endtask
endmodule
`default_nettype wire

// ==== sim/ctd_regs_properties.sv ====
`default_nettype none
// ==========
// Port checker
module ctd_regs_chk
   import ctd_pkg::*;
(
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        nrst_in,
   // Coprocessor transfer
   input wire logic        xfer_valid_in,
   input wire logic        xfer_dir_in,
   input wire logic [3:0]  primary_reg_in,
   input wire logic [2:0]  first_op_field_in,
   input wire logic [3:0]  secondary_reg_field_in,
   input wire logic [2:0]  second_op_field_in,
   input wire logic [31:0] wdata_in,
   input wire logic [31:0] rdata_out,
   input wire logic        rhit_out,
   // Trace stall
   input wire logic        trace_buffer_full_in,
   input wire logic        fast_interrupt_n_in,
   input wire logic        normal_interrupt_n_in,
   input wire logic        core_stall_out
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [13:0] SA = {CTD_PRIMARY_REG, CTD_OP1_ADDR, CTD_SEC_REG_ADDR, CTD_OP2_ADDR};
   localparam logic [13:0] ST = {CTD_PRIMARY_REG, CTD_OP1_TRACE, CTD_SEC_REG_ADDR, CTD_OP2_ADDR};
   localparam logic [13:0] SO = {CTD_PRIMARY_REG, CTD_OP1_OVERRIDE, CTD_SEC_REG_OVR, CTD_OP2_OVERRIDE};
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   logic [13:0] s;
   logic        rd;
   assign s = {primary_reg_in, first_op_field_in, secondary_reg_field_in, second_op_field_in};
   assign rd = xfer_valid_in && !xfer_dir_in;
   sequence s_wr_a; xfer_valid_in && xfer_dir_in && s == SA; endsequence
   sequence s_rd_a; rd && s == SA; endsequence
   AST_ADDR_RD: assert property (s_wr_a ##1 s_rd_a |=> rhit_out && rdata_out == $past(wdata_in, 2))
      else $error("address readback wrong");
   AST_TRC_RD: assert property (rd && s == ST |=> rhit_out && (rdata_out & ~CTD_TRC_MASK) == 32'h0)
      else $error("trace read wrong");
   AST_OVR_RD: assert property (rd && s == SO |=> rhit_out && (rdata_out & ~CTD_OVR_MASK) == 32'h0)
      else $error("override read wrong");
   AST_NO_HIT: assert property (xfer_valid_in && primary_reg_in != CTD_PRIMARY_REG |=> !rhit_out)
      else $error("foreign transfer answered");
   AST_HIT_SRC: assert property (rhit_out |-> $past(rd))
      else $error("hit without read");
   AST_IDLE_DATA: assert property (!rhit_out |-> rdata_out == 32'h0)
      else $error("read data without hit");
   AST_STALL: assert property (trace_buffer_full_in && fast_interrupt_n_in && normal_interrupt_n_in |-> core_stall_out)
      else $error("missing stall");
   AST_NO_STALL: assert property (!trace_buffer_full_in |-> !core_stall_out)
      else $error("stall without full");
endmodule
bind ctd_regs ctd_regs_chk u_chk (.*);
`default_nettype wire

// ==== sim/test_coproc_test_debug_regs.sv ====
`default_nettype none
// ==========
// Bench
module test_coproc_test_debug_regs
   import ctd_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic [12:0] ev = 13'h0000;
   logic [31:0] rs = 32'h0001_5DA4;
   logic [31:0] q[$];
   logic [31:0] a, o, t, rd, ta;
   logic [1:0]  p;
   logic [3:0]  fs;
   logic        rh, st, dw, iw, da, ia, cl, pf, cg;
   ctd_policy_e pol;
   int          num_errors = 0;
   int          checks = 0;
   wire logic        v, dir;
   wire logic [13:0] sel;
   wire logic [31:0] wd;
   always #50 clk_in = ~clk_in;
   ctd_core_model M (.clk_in(clk_in), .vld_out(v), .dir_out(dir), .sel_out(sel), .wd_out(wd));
   ctd_regs DUT (.clk_in(clk_in), .nrst_in(nrst_in), .xfer_valid_in(v), .xfer_dir_in(dir),
      .primary_reg_in(sel[13:10]), .first_op_field_in(sel[9:7]), .secondary_reg_field_in(sel[6:3]),
      .second_op_field_in(sel[2:0]), .wdata_in(wd), .rdata_out(rd), .rhit_out(rh), .test_addr_out(ta),
      .trace_buffer_full_in(ev[12]), .fast_interrupt_n_in(ev[11]), .normal_interrupt_n_in(ev[10]),
      .core_stall_out(st), .dxlate_miss_in(ev[9]), .ixlate_miss_in(ev[8]), .d_walk_out(dw), .i_walk_out(iw),
      .d_abort_out(da), .i_abort_out(ia), .fault_status_out(fs), .clean_whole_cache_out(cl),
      .spec_prefetch_en_out(pf), .cgate_en_out(cg), .mmu_en_in(ev[7]), .data_cache_en_in(ev[6]),
      .remap_valid_in(ev[5]), .remap_policy_in(ctd_policy_e'(ev[3:2])),
      .page_policy_in(ctd_policy_e'(ev[1:0])), .is_store_in(ev[4]), .data_policy_out(pol));
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic rdx(input logic [13:0] s, input logic [31:0] e);
      q.push_back(e);
      M.xfer(1'b0, s, rnd());
   endtask
   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Answers are taken at the falling edge, where the registered word has settled
   always @(negedge clk_in) begin
      if (rh === 1'b1 && q.size() == 0)
         chk(32'h1, 32'h0);
      else if (rh === 1'b1)
         chk(rd, q.pop_front());
   end
   initial begin
      #200_000;
      num_errors++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge clk_in);
      #1 nrst_in = 1'b1;
      rdx(M.S_OVR, 32'h0);
      rdx(M.S_TRC, 32'h0);
      for (int i = 0; i < 8; i++) begin
         a = rnd();
         o = rnd();
         t = {29'h0, i[1:0], 1'b0};
         M.xfer(1'b1, M.S_ADR, a);
         chk(ta, a);
         rdx(M.S_ADR, a);
         M.xfer(1'b1, M.S_OVR, o);
         M.xfer(1'b1, M.S_TRC, t | 32'hFFFF_FFF9);
         M.xfer(1'b1, {4'hE, M.S_ADR[9:0]}, ~a);
         M.xfer(1'b0, {4'hE, M.S_ADR[9:0]}, 32'h0000_0000);
         rdx(M.S_ADR, a);
         rdx(M.S_OVR, o & CTD_OVR_MASK);
         rdx(M.S_TRC, t);
         M.idle();
         chk({29'h0, cl, pf, cg}, {29'h0, o[19], !o[16], !o[15]});
         for (int j = 0; j < 16; j++) begin
            ev = 13'(rnd());
            p = ev[7] ? ev[1:0] : (o[13] && ev[6] ? CTD_POL_WRTHRU : CTD_POL_UNCACHED);
            if (ev[5])
               p = ev[3:2];
            if (o[14] && ev[4] && p == CTD_POL_BUFFERED)
               p = CTD_POL_UNCACHED;
            #10;
            chk({21'h0, da, dw, ia, iw, st, fs, pol}, {21'h0, ev[9] & o[18], ev[9] & !o[18], ev[8] & o[17],
               ev[8] & !o[17], ev[12] & (ev[11] | t[2]) & (ev[10] | t[1]), CTD_FAULT_XLATE, p});
            @(posedge clk_in);
            #1;
         end
      end
      nrst_in = 1'b0;
      repeat (2) @(posedge clk_in);
      #1 nrst_in = 1'b1;
      rdx(M.S_OVR, 32'h0);
      rdx(M.S_TRC, 32'h0);
      M.idle();
      repeat (2) @(posedge clk_in);
      chk(32'(q.size()), 32'h0);
      test_done();
   end
endmodule
`default_nettype wire

// ==== src/ctd_ctrl.sv ====
`default_nettype none
module ctd_ctrl
   import ctd_pkg::*;
(
   // Register view
   ctd_ovr_if.ctrl           ovr,
   // Trace stall
   input  wire logic         trace_buffer_full_in,
   input  wire logic         fast_interrupt_n_in,
   input  wire logic         normal_interrupt_n_in,
   output logic              core_stall_out,
   // Translation miss
   input  wire logic         dxlate_miss_in,
   input  wire logic         ixlate_miss_in,
   output logic              d_walk_out,
   output logic              i_walk_out,
   output logic              d_abort_out,
   output logic              i_abort_out,
   output logic [3:0]        fault_status_out,
   // Misc policies
   output logic              clean_whole_cache_out,
   output logic              spec_prefetch_en_out,
   output logic              cgate_en_out,
   input  wire logic         mmu_en_in,
   input  wire logic         data_cache_en_in,
   input  wire logic         remap_valid_in,
   input  wire ctd_policy_e  remap_policy_in,
   input  wire ctd_policy_e  page_policy_in,
   input  wire logic         is_store_in,
   output ctd_policy_e       data_policy_out
);
   logic fiq_pend;
   logic irq_pend;
   assign fiq_pend = !fast_interrupt_n_in;
   assign irq_pend = !normal_interrupt_n_in;
   assign core_stall_out = trace_buffer_full_in
                           && !(fiq_pend && !ovr.trace_reg[CTD_TRC_FIQ])
                           && !(irq_pend && !ovr.trace_reg[CTD_TRC_IRQ]);
   assign d_abort_out = dxlate_miss_in && ovr.override_reg[CTD_OVR_ABORT_D];
   assign i_abort_out = ixlate_miss_in && ovr.override_reg[CTD_OVR_ABORT_I];
   assign d_walk_out  = dxlate_miss_in && !ovr.override_reg[CTD_OVR_ABORT_D];
   assign i_walk_out  = ixlate_miss_in && !ovr.override_reg[CTD_OVR_ABORT_I];
   assign fault_status_out = CTD_FAULT_XLATE;
   assign clean_whole_cache_out = ovr.override_reg[CTD_OVR_CLEAN_ALL];
   assign spec_prefetch_en_out = !ovr.override_reg[CTD_OVR_NO_PREF];
   // clock gating only, no functional effect
   assign cgate_en_out = !ovr.override_reg[CTD_OVR_NO_CGATE];
   always_comb begin
      ctd_policy_e pol;
      pol = page_policy_in;
      if (!mmu_en_in) begin
         pol = CTD_POL_UNCACHED;
         if (ovr.override_reg[CTD_OVR_MMUOFF_WRTHRU] && data_cache_en_in) begin
            pol = CTD_POL_WRTHRU;
         end
      end
      if (remap_valid_in) begin
         pol = remap_policy_in;
      end
      // Forcing unbuffered stores wins over both page tables and remap
      if (ovr.override_reg[CTD_OVR_FORCE_UNBUF] && is_store_in && pol == CTD_POL_BUFFERED) begin
         pol = CTD_POL_UNCACHED;
      end
      data_policy_out = pol;
   end
endmodule
`default_nettype wire

// ==== src/ctd_regs.sv ====
`default_nettype none
// Notes on behaviour
// - Primary register c15 selects this bank
// - Direction bit one writes, zero reads
// - Override register resets to zero
// - Override reserved bits; software writes zero
// - Bit 19 cleans the whole data cache
// - Bits 18/17 abort translation misses, status 0000
// - Bit 16 clear allows speculative prefetch
// - Bit 16 set stops noncacheable prefetch
// - Bit 15 disables block clock gating
// - Bit 14 forces bufferable stores unbuffered
// - MMU off: unbuffered, or write-through
// - Remap outranks bit 13 write-through
// - Address register at op1 0, c1, op2 0
// - Trace control at op1 1, c1, op2 0
// - Trace bits 2 and 1 reset clear
// - Bit 2 clear: fast interrupt blocks stall
// - Bit 1 clear: normal interrupt blocks stall
module ctd_regs
   import ctd_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         nrst_in,
   // Coprocessor transfer
   input  wire logic         xfer_valid_in,
   input  wire logic         xfer_dir_in,
   input  wire logic [3:0]   primary_reg_in,
   input  wire logic [2:0]   first_op_field_in,
   input  wire logic [3:0]   secondary_reg_field_in,
   input  wire logic [2:0]   second_op_field_in,
   input  wire logic [31:0]  wdata_in,
   output logic [31:0]       rdata_out,
   output logic              rhit_out,
   output logic [31:0]       test_addr_out,
   // Trace stall
   input  wire logic         trace_buffer_full_in,
   input  wire logic         fast_interrupt_n_in,
   input  wire logic         normal_interrupt_n_in,
   output logic              core_stall_out,
   // Translation miss
   input  wire logic         dxlate_miss_in,
   input  wire logic         ixlate_miss_in,
   output logic              d_walk_out,
   output logic              i_walk_out,
   output logic              d_abort_out,
   output logic              i_abort_out,
   output logic [3:0]        fault_status_out,
   // Memory policies and clock gating
   output logic              clean_whole_cache_out,
   output logic              spec_prefetch_en_out,
   output logic              cgate_en_out,
   input  wire logic         mmu_en_in,
   input  wire logic         data_cache_en_in,
   input  wire logic         remap_valid_in,
   input  wire ctd_policy_e  remap_policy_in,
   input  wire ctd_policy_e  page_policy_in,
   input  wire logic         is_store_in,
   output ctd_policy_e       data_policy_out
);
   // ==========================================================
   // Decode
   ctd_ovr_if ovr ();
   logic [31:0] override_reg;
   logic [31:0] trace_reg;
   logic [31:0] test_addr;
   logic        bank_sel;
   logic        sel_ovr;
   logic        sel_addr;
   logic        sel_trc;
   logic        wr_en;
   logic        rd_en;
   assign bank_sel = xfer_valid_in && primary_reg_in == CTD_PRIMARY_REG;
   assign sel_ovr  = bank_sel && first_op_field_in == CTD_OP1_OVERRIDE
                     && secondary_reg_field_in == CTD_SEC_REG_OVR
                     && second_op_field_in == CTD_OP2_OVERRIDE;
   assign sel_addr = bank_sel && first_op_field_in == CTD_OP1_ADDR
                     && secondary_reg_field_in == CTD_SEC_REG_ADDR
                     && second_op_field_in == CTD_OP2_ADDR;
   assign sel_trc  = bank_sel && first_op_field_in == CTD_OP1_TRACE
                     && secondary_reg_field_in == CTD_SEC_REG_ADDR
                     && second_op_field_in == CTD_OP2_ADDR;
   assign wr_en = xfer_dir_in;
   assign rd_en = !xfer_dir_in;

   // ==========================================================
   // Registers
   // override reset zero
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         override_reg <= CTD_OVR_RESET;
      end else if (sel_ovr && wr_en) begin
         override_reg <= wdata_in & CTD_OVR_MASK;
      end
   end
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         trace_reg <= CTD_TRC_RESET;
      end else if (sel_trc && wr_en) begin
         trace_reg <= wdata_in & CTD_TRC_MASK;
      end
   end
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         test_addr <= CTD_ADDR_RESET;
      end else if (sel_addr && wr_en) begin
         test_addr <= wdata_in;
      end
   end
   // Read data registered so it lines up one cycle after the request
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_out <= 32'h0000_0000;
         rhit_out  <= 1'b0;
      end else begin
         rhit_out <= rd_en && (sel_ovr || sel_addr || sel_trc);
         if (rd_en && sel_ovr) begin
            rdata_out <= override_reg;
         end else if (rd_en && sel_addr) begin
            rdata_out <= test_addr;
         end else if (rd_en && sel_trc) begin
            rdata_out <= trace_reg;
         end else begin
            rdata_out <= 32'h0000_0000;
         end
      end
   end
   assign test_addr_out    = test_addr;
   assign ovr.override_reg = override_reg;
   assign ovr.trace_reg    = trace_reg;

   // ==========================================================
   // Control effects
   ctd_ctrl u_ctrl (
      .ovr                   (ovr.ctrl),
      .trace_buffer_full_in  (trace_buffer_full_in),
      .fast_interrupt_n_in   (fast_interrupt_n_in),
      .normal_interrupt_n_in (normal_interrupt_n_in),
      .core_stall_out        (core_stall_out),
      .dxlate_miss_in        (dxlate_miss_in),
      .ixlate_miss_in        (ixlate_miss_in),
      .d_walk_out            (d_walk_out),
      .i_walk_out            (i_walk_out),
      .d_abort_out           (d_abort_out),
      .i_abort_out           (i_abort_out),
      .fault_status_out      (fault_status_out),
      .clean_whole_cache_out (clean_whole_cache_out),
      .spec_prefetch_en_out  (spec_prefetch_en_out),
      .cgate_en_out          (cgate_en_out),
      .mmu_en_in             (mmu_en_in),
      .data_cache_en_in      (data_cache_en_in),
      .remap_valid_in        (remap_valid_in),
      .remap_policy_in       (remap_policy_in),
      .page_policy_in        (page_policy_in),
      .is_store_in           (is_store_in),
      .data_policy_out       (data_policy_out)
   );
endmodule
`default_nettype wire
